/* File: hw/gia_pkg.sv */
// Purpose: Shared constants and types of the global interrupt aggregator
// Assumes: Register index n sits at Wishbone byte address 4*n
// Notes: Indices are kept as printed; the bus decodes adr_i[9:2]
`default_nettype none

package gia_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int GIA_PORTS = 8;
    localparam int GIA_GROUPS = 3;
    localparam int GIA_ADR_W = 10;
    localparam int GIA_DAT_W = 32;
    localparam int GIA_SEL_W = 4;

    // ------------------------------------------------------------
    // Group positions
    // ------------------------------------------------------------
    localparam int GIA_GRP_FRAMER = 0;
    localparam int GIA_GRP_TESTER = 1;
    localparam int GIA_GRP_LINE = 2;

    // ------------------------------------------------------------
    // Register indices (byte address = 4 * index)
    // ------------------------------------------------------------
    localparam logic [7:0] GIA_IDX_EVENT_STATUS = 8'hf0;
    localparam logic [7:0] GIA_IDX_EVENT_MASK = 8'hf1;
    localparam logic [7:0] GIA_IDX_FRAMER_STATUS = 8'hf9;
    localparam logic [7:0] GIA_IDX_TESTER_STATUS = 8'hfa;
    localparam logic [7:0] GIA_IDX_LINE_STATUS = 8'hfb;
    localparam logic [7:0] GIA_IDX_FRAMER_MASK = 8'hfc;
    localparam logic [7:0] GIA_IDX_TESTER_MASK = 8'hfd;
    localparam logic [7:0] GIA_IDX_LINE_MASK = 8'hfe;

    // ------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------
    localparam logic [7:0] GIA_STATUS_RST = 8'h00;
    localparam logic [7:0] GIA_MASK_RST = 8'h00;
    localparam logic [2:0] GIA_EVT_RST = 3'h0;
    localparam logic [31:0] GIA_DAT_RST = 32'h0000_0000;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic {GIA_BUS_IDLE, GIA_BUS_ACK} gia_bus_t;

    typedef struct packed {
        gia_bus_t bus;
        logic ack;
        logic [GIA_DAT_W-1:0] dat;
        logic [GIA_GROUPS-1:0][GIA_PORTS-1:0] status;
        logic [GIA_GROUPS-1:0][GIA_PORTS-1:0] mask;
        logic [GIA_GROUPS-1:0] evt;
        logic [GIA_GROUPS-1:0] evt_mask;
        logic irq;
        logic evt_irq;
    } gia_state_t;

    // ------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------
    function automatic logic gia_is_mask(input logic [7:0] idx);
        return (idx >= GIA_IDX_FRAMER_MASK) && (idx <= GIA_IDX_LINE_MASK);
    endfunction

    function automatic logic gia_is_status(input logic [7:0] idx);
        return (idx >= GIA_IDX_FRAMER_STATUS) && (idx <= GIA_IDX_LINE_STATUS);
    endfunction

    function automatic logic [1:0] gia_mask_grp(input logic [7:0] idx);
        logic [7:0] d;
        d = idx - GIA_IDX_FRAMER_MASK;
        return d[1:0];
    endfunction

    function automatic logic [1:0] gia_status_grp(input logic [7:0] idx);
        logic [7:0] d;
        d = idx - GIA_IDX_FRAMER_STATUS;
        return d[1:0];
    endfunction

endpackage

`default_nettype wire

/* File: hw/gia_bank.sv */
// Purpose: Gating and edge finding for one group of eight sources
// Assumes: src_i and mask_i are next-state values from the aggregator, prev_i the registered status
// Notes: Purely combinational
`default_nettype none

module gia_bank (
    input wire logic [7:0] src_i,
    input wire logic [7:0] prev_i,
    input wire logic [7:0] mask_i,
    output logic pend_o,
    output logic rise_o
);
    import gia_pkg::*;

    // ------------------------------------------------------------
    // Masked request and new request
    // ------------------------------------------------------------
    always_comb begin
        pend_o = |(src_i & mask_i);
        rise_o = |(src_i & ~prev_i);
    end

endmodule

`default_nettype wire

/* File: hw/gia_top.sv */
// Purpose: Global interrupt aggregator for framer, tester and line-unit sources
// Assumes: Source requests are levels synchronous to clk_i
// Notes: Classic Wishbone slave, one wait state, 32-bit data, low byte used
// Operation
// - Tester status: one bit per port
// - Line-unit status: one bit per port
// - Framer status bit 0 is framer 1
// - Framer mask bit gates framer, one enables
// - Tester mask bit gates tester, one enables
// - Line-unit mask bit gates line unit
// - Tester/line status at FA/FB, read-only, zero
// - Masks at FC/FD/FE, read/write, reset zero
// - Framer status at F9, read-only
`default_nettype none

module gia_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [gia_pkg::GIA_ADR_W-1:0] adr_i,
    input wire logic [gia_pkg::GIA_SEL_W-1:0] sel_i,
    input wire logic [gia_pkg::GIA_DAT_W-1:0] dat_i,
    output logic [gia_pkg::GIA_DAT_W-1:0] dat_o,
    output logic ack_o,
    input wire logic [gia_pkg::GIA_PORTS-1:0] framer_irq_i,
    input wire logic [gia_pkg::GIA_PORTS-1:0] tester_irq_i,
    input wire logic [gia_pkg::GIA_PORTS-1:0] line_unit_irq_i,
    output logic irq_o,
    output logic evt_irq_o
);
    import gia_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    gia_state_t s;
    gia_state_t n;
    logic [GIA_GROUPS-1:0][GIA_PORTS-1:0] src;
    logic [GIA_GROUPS-1:0][GIA_PORTS-1:0] next_mask;
    logic [GIA_GROUPS-1:0] pend;
    logic [GIA_GROUPS-1:0] rise;
    logic [7:0] idx;
    logic req;

    assign idx = adr_i[9:2];
    assign req = cyc_i & stb_i;

    always_comb begin
        src[GIA_GRP_FRAMER] = framer_irq_i;
        src[GIA_GRP_TESTER] = tester_irq_i;
        src[GIA_GRP_LINE] = line_unit_irq_i;
    end

    // ------------------------------------------------------------
    // Mask update seen by the gating logic
    // ------------------------------------------------------------
    always_comb begin
        next_mask = s.mask;
        if (s.bus == GIA_BUS_ACK && req && we_i && sel_i[0] && gia_is_mask(idx)) begin
            next_mask[gia_mask_grp(idx)] = dat_i[7:0];
        end
    end

    // ------------------------------------------------------------
    // Per-group gating
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < GIA_GROUPS; g++) begin : g_bank
            gia_bank u_bank (
                .src_i(src[g]),
                .prev_i(s.status[g]),
                .mask_i(next_mask[g]),
                .pend_o(pend[g]),
                .rise_o(rise[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        n = s;
        n.status = src;
        n.mask = next_mask;
        n.ack = 1'b0;
        case (s.bus)
            GIA_BUS_IDLE: begin
                if (req) begin
                    n.bus = GIA_BUS_ACK;
                    n.ack = 1'b1;
                    n.dat = GIA_DAT_RST;
                    if (!we_i) begin
                        if (gia_is_status(idx)) begin
                            n.dat[7:0] = s.status[gia_status_grp(idx)];
                        end else if (gia_is_mask(idx)) begin
                            n.dat[7:0] = s.mask[gia_mask_grp(idx)];
                        end else if (idx == GIA_IDX_EVENT_STATUS) begin
                            n.dat[2:0] = s.evt | rise;
                        end else if (idx == GIA_IDX_EVENT_MASK) begin
                            n.dat[2:0] = s.evt_mask;
                        end
                    end
                end
            end
            GIA_BUS_ACK: begin
                n.bus = GIA_BUS_IDLE;
                if (req && we_i && sel_i[0] && idx == GIA_IDX_EVENT_MASK) begin
                    n.evt_mask = dat_i[2:0];
                end
                if (req && !we_i && idx == GIA_IDX_EVENT_STATUS) begin
                    n.evt = GIA_EVT_RST;
                end
            end
            default: begin
                n.bus = GIA_BUS_IDLE;
            end
        endcase
        // New events win over a clearing read
        n.evt = n.evt | rise;
        n.irq = |pend;
        n.evt_irq = |(n.evt & n.evt_mask);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s.bus <= GIA_BUS_IDLE;
            s.ack <= 1'b0;
            s.dat <= GIA_DAT_RST;
            s.status <= {GIA_GROUPS{GIA_STATUS_RST}};
            s.mask <= {GIA_GROUPS{GIA_MASK_RST}};
            s.evt <= GIA_EVT_RST;
            s.evt_mask <= GIA_EVT_RST;
            s.irq <= 1'b0;
            s.evt_irq <= 1'b0;
        end else begin
            s <= n;
        end
    end

    assign dat_o = s.dat;
    assign ack_o = s.ack;
    assign irq_o = s.irq;
    assign evt_irq_o = s.evt_irq;

endmodule

`default_nettype wire

/* File: tb/gia_monitor.sv */
// Purpose: Port checks for the interrupt aggregator
// Assumes: Mask writes land at the ack edge
// Notes: Keeps a shadow of the three mask registers
`default_nettype none
module gia_monitor (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [9:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic [7:0] framer_irq_i,
    input wire logic [7:0] tester_irq_i,
    input wire logic [7:0] line_unit_irq_i,
    input wire logic irq_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0][7:0] msk;
    logic [7:0] idx;
    logic rd;
    logic req;
    assign idx = adr_i[9:2];
    assign req = cyc_i && stb_i;
    assign rd = req && ack_o && !we_i;
    always_ff @(posedge clk_i) begin
        if (rst_i)
            msk <= '0;
        else if (req && ack_o && we_i && sel_i[0] && idx >= 8'hfc && idx <= 8'hfe)
            msk[idx[1:0]] <= dat_i[7:0];
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack too long");
    ack_delay_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack late");
    irq_level_a: assert property (irq_o == |({$past(line_unit_irq_i),
        $past(tester_irq_i), $past(framer_irq_i)} & msk)) else $error("irq level");
    tst_gate_a: assert property (|($past(tester_irq_i) & msk[1]) |-> irq_o)
        else $error("tester gate");
    frm_status_a: assert property (rd && idx == 8'hf9
        |-> dat_o[7:0] == $past(framer_irq_i, 2)) else $error("framer status");
    tst_status_a: assert property (rd && idx == 8'hfa
        |-> dat_o[7:0] == $past(tester_irq_i, 2)) else $error("tester status");
    lin_status_a: assert property (rd && idx == 8'hfb
        |-> dat_o[7:0] == $past(line_unit_irq_i, 2)) else $error("line status");
    mask_read_a: assert property (rd && idx == 8'hfd |-> dat_o[7:0] == msk[1])
        else $error("mask read");
    data_upper_a: assert property (ack_o |-> dat_o[31:8] == 24'h00_0000) else $error("upper");
    cover property (irq_o);
    cover property (ack_o && we_i);
    cover property (rd && idx == 8'hfa);
endmodule
bind gia_top gia_monitor mon (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .framer_irq_i(framer_irq_i), .tester_irq_i(tester_irq_i),
    .line_unit_irq_i(line_unit_irq_i), .irq_o(irq_o));
`default_nettype wire

/* File: tb/gia_src_model.sv */
// Purpose: Framer, tester and line-unit request sources
// Assumes: Bench sets wanted levels on req_i
// Notes: Levels follow req_i one clock later
`default_nettype none
module gia_src_model (
    input wire logic clk_i,
    input wire logic [23:0] req_i,
    output logic [23:0] irq_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial irq_o = 24'h00_0000;
    always @(posedge clk_i) begin
        irq_o <= req_i;
    end
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// Purpose: Self-checking bench for the interrupt aggregator
// Assumes: Register index i sits at byte address 4*i
// Notes: Sources packed as line, tester, framer
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; \
    $display("BAD %0t got %h exp %h", $time, a, b); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack, irq, evt;
    logic [9:0] adr = '0;
    logic [3:0] sel = 4'hf;
    logic [31:0] dat = '0, dat_r;
    logic [23:0] req = '0, src;
    logic [7:0] q;
    int mismatches = 0, checked = 0;
    always #50 clk = ~clk;
    gia_src_model far (.clk_i(clk), .req_i(req), .irq_o(src));
    gia_top dut (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(sel), .dat_i(dat), .dat_o(dat_r), .ack_o(ack), .framer_irq_i(src[7:0]),
        .tester_irq_i(src[15:8]), .line_unit_irq_i(src[23:16]), .irq_o(irq), .evt_irq_o(evt));
    task automatic hold(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= {i, 2'b00};
        dat <= {24'h00_0000, d};
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = dat_r[7:0];
        cyc <= 0;
        stb <= 0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] i, input logic [7:0] e);
        bus(1'b0, i, 8'h00);
        `CHK(q, e)
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        bus(1'b1, i, d);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        logic [7:0] r [9] = '{8'hf9, 8'hfa, 8'hfb, 8'hfc, 8'hfd, 8'hfe, 8'hf0, 8'hf1, 8'h80};
        foreach (r[k])
            rd(r[k], 8'h00);
        `CHK(irq, 1'b0)
    endtask
    task automatic t_status;
        req <= 24'ha5_8081;
        hold(3);
        rd(8'hf9, 8'h81);
        rd(8'hfa, 8'h80);
        rd(8'hfb, 8'ha5);
        wr(8'hfa, 8'hff);
        wr(8'hf9, 8'hff);
        wr(8'h80, 8'hff);
        rd(8'hfa, 8'h80);
        rd(8'hf9, 8'h81);
        rd(8'h80, 8'h00);
        `CHK(irq, 1'b0)
    endtask
    task automatic t_mask;
        logic [7:0] s;
        for (int g = 0; g < 3; g++) begin
            s = req[8*g +: 8];
            wr(8'hfc + 8'(g), ~s);
            `CHK(irq, 1'b0)
            wr(8'hfc + 8'(g), s);
            `CHK(irq, 1'b1)
            rd(8'hfc + 8'(g), s);
            sel <= 4'he;
            wr(8'hfc + 8'(g), 8'h00);
            sel <= 4'hf;
            `CHK(irq, 1'b1)
            wr(8'hfc + 8'(g), 8'h00);
        end
    endtask
    task automatic t_follow;
        wr(8'hfd, 8'h80);
        `CHK(irq, 1'b1)
        req <= 24'ha5_0001;
        hold(3);
        `CHK(irq, 1'b0)
        rd(8'hfa, 8'h00);
        wr(8'hfd, 8'h00);
    endtask
    task automatic t_event;
        rd(8'hf0, 8'h07);
        rd(8'hf0, 8'h00);
        wr(8'hf1, 8'h02);
        req <= 24'ha5_0003;
        hold(3);
        `CHK(evt, 1'b0)
        wr(8'hf1, 8'h07);
        hold(1);
        `CHK(evt, 1'b1)
        rd(8'hf0, 8'h01);
        hold(1);
        `CHK(evt, 1'b0)
    endtask
    task automatic complete_run;
        if (mismatches == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        hold(8);
        rst <= 0;
        hold(1);
        t_reset;
        t_status;
        t_mask;
        t_follow;
        t_event;
        complete_run;
    end
    initial begin
        hold(3000);
        mismatches++;
        complete_run;
    end
endmodule
`default_nettype wire
